// *** core/ptmr_map.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the timer package users; definitions only
`ifndef PTMR_MAP_SVH
`define PTMR_MAP_SVH

// Register offsets on the plain register port
`define PTMR_OFF_CONTROL    3'h0
`define PTMR_OFF_COUNT      3'h1
`define PTMR_OFF_PERIOD     3'h2
`define PTMR_OFF_FLAGS      3'h3
`define PTMR_OFF_ENABLE     3'h4

// Control field positions
`define PTMR_CTL_PRE_LSB    0
`define PTMR_CTL_RUN_BIT    2
`define PTMR_CTL_POST_LSB   3
`define PTMR_CTL_WMASK      8'h7F

// Flag and enable bit for the match event
`define PTMR_MATCH_BIT      1
`define PTMR_IRQ_WMASK      8'h02

// Reset values
`define PTMR_RST_CONTROL    8'h00
`define PTMR_RST_COUNT      8'h00
`define PTMR_RST_PERIOD     8'hFF
`define PTMR_RST_FLAGS      8'h00
`define PTMR_RST_ENABLE     8'h00

// Instruction clock is the core clock divided by four
`define PTMR_INSTR_DIV      2'h3
// Prescale terminal counts: divide by 1, 4, 16
`define PTMR_PRE_TC_1       4'h0
`define PTMR_PRE_TC_4       4'h3
`define PTMR_PRE_TC_16      4'hF

`endif

// *** core/ptmr_pkg.sv ***
// Types shared by the period timer
// Assumes the map header sits beside it in core/
package ptmr_pkg;
    typedef enum logic [1:0] {
        PTMR_PRE_DIV1,
        PTMR_PRE_DIV4,
        PTMR_PRE_DIV16A,
        PTMR_PRE_DIV16B
    } ptmr_pre_t;
endpackage

// *** core/ptmr_timer.sv ***
// 8-bit period timer with prescaler, postscaler and match interrupt
// Assumes a single 20 MHz clock (mclk), synchronous reset, plain register port
//
// What this block does
// - Counting clock is instruction clock, core clock over four, through prescaler
// - Prescale select: 00 divide 1, 01 divide 4, 1x divide 16
// - Each prescaler pulse adds one to the count while running
// - Count compared with period continuously, counting up from 00h
// - On equal, count returns to 00h at next increment
// - Every match steps the postscaler by one
// - Postscale select plus one matches yield one postscaler output
// - Postscaler output sets the match interrupt flag
// - Count and period registers fully readable and writable
// - Reset loads count with 00h and period with FFh
// - Control bit 2 starts timer when one, halts when zero
// - Count write, control write or reset clears prescaler and postscaler
// - Control write leaves the count unchanged
// - Control bit 7 ignores writes and reads zero
//
// The placing of the registers and the plain strobed port were decided locally.
`include "ptmr_map.svh"

module ptmr_timer
    import ptmr_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       srst,
    // Register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Interrupt request
    output logic            irq
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] control_reg;
    logic [7:0] count_reg;
    logic [7:0] period_reg;
    logic [7:0] flags_reg;
    logic [7:0] enable_reg;
    logic [1:0] instr_reg;
    logic [3:0] pre_reg;
    logic [3:0] post_reg;
    logic [7:0] rdata_reg;
    logic       irq_reg;

    logic       wr_ctl;
    logic       wr_cnt;
    logic       wr_per;
    logic       wr_flg;
    logic       wr_ena;
    logic       run;
    logic       instr_tick;
    logic       pre_tick;
    logic       match;
    logic       post_tick;
    logic [3:0] pre_tc;
    logic [3:0] post_sel;
    ptmr_pre_t  pre_sel;

    ////////////////////////////////////////////////////////////////////////
    // Decode and fields
    assign wr_ctl   = reg_wr && (reg_addr == `PTMR_OFF_CONTROL);
    assign wr_cnt   = reg_wr && (reg_addr == `PTMR_OFF_COUNT);
    assign wr_per   = reg_wr && (reg_addr == `PTMR_OFF_PERIOD);
    assign wr_flg   = reg_wr && (reg_addr == `PTMR_OFF_FLAGS);
    assign wr_ena   = reg_wr && (reg_addr == `PTMR_OFF_ENABLE);
    assign run      = control_reg[`PTMR_CTL_RUN_BIT];
    assign pre_sel  = ptmr_pre_t'(control_reg[`PTMR_CTL_PRE_LSB +: 2]);
    assign post_sel = control_reg[`PTMR_CTL_POST_LSB +: 4];

    // Prescale terminal count from the select field
    always_comb begin
        case (pre_sel)
            PTMR_PRE_DIV1: pre_tc = `PTMR_PRE_TC_1;
            PTMR_PRE_DIV4: pre_tc = `PTMR_PRE_TC_4;
            default:       pre_tc = `PTMR_PRE_TC_16;
        endcase
    end

    // Tick chain: instruction clock, prescaler, match, postscaler
    assign instr_tick = run && (instr_reg == `PTMR_INSTR_DIV);
    assign pre_tick   = instr_tick && (pre_reg == pre_tc);
    assign match      = (count_reg == period_reg);
    assign post_tick  = pre_tick && match && (post_reg == post_sel);

    ////////////////////////////////////////////////////////////////////////
    // Control register; bit 7 never stored
    always_ff @(posedge mclk) begin
        if (srst) begin
            control_reg <= `PTMR_RST_CONTROL;
        end else if (wr_ctl) begin
            control_reg <= reg_wdata & `PTMR_CTL_WMASK;
        end
    end

    // Instruction clock phase; free runs only while on
    always_ff @(posedge mclk) begin
        if (srst) begin
            instr_reg <= 2'h0;
        end else if (run) begin
            instr_reg <= instr_reg + 2'h1;
        end
    end

    // Prescaler; cleared on count or control write
    always_ff @(posedge mclk) begin
        if (srst || wr_ctl || wr_cnt) begin
            pre_reg <= 4'h0;
        end else if (instr_tick) begin
            pre_reg <= pre_tick ? 4'h0 : pre_reg + 4'h1;
        end
    end

    // Count; a control write does not touch it
    always_ff @(posedge mclk) begin
        if (srst) begin
            count_reg <= `PTMR_RST_COUNT;
        end else if (wr_cnt) begin
            count_reg <= reg_wdata;
        end else if (pre_tick) begin
            count_reg <= match ? 8'h00 : count_reg + 8'h01;
        end
    end

    // Period register
    always_ff @(posedge mclk) begin
        if (srst) begin
            period_reg <= `PTMR_RST_PERIOD;
        end else if (wr_per) begin
            period_reg <= reg_wdata;
        end
    end

    // Postscaler steps once per match
    always_ff @(posedge mclk) begin
        if (srst || wr_ctl || wr_cnt) begin
            post_reg <= 4'h0;
        end else if (pre_tick && match) begin
            post_reg <= post_tick ? 4'h0 : post_reg + 4'h1;
        end
    end

    // Sticky flag, write one to clear; a new event beats the clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            flags_reg <= `PTMR_RST_FLAGS;
        end else begin
            if (wr_flg) begin
                flags_reg <= flags_reg & ~(reg_wdata & `PTMR_IRQ_WMASK);
            end
            if (post_tick) begin
                flags_reg[`PTMR_MATCH_BIT] <= 1'b1;
            end
        end
    end

    // Enable mask
    always_ff @(posedge mclk) begin
        if (srst) begin
            enable_reg <= `PTMR_RST_ENABLE;
        end else if (wr_ena) begin
            enable_reg <= reg_wdata & `PTMR_IRQ_WMASK;
        end
    end

    // Interrupt level from flag and mask
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(flags_reg & enable_reg);
        end
    end

    // Read data in the cycle after the strobe, zero otherwise
    always_ff @(posedge mclk) begin
        if (srst || !reg_rd) begin
            rdata_reg <= 8'h00;
        end else begin
            case (reg_addr)
                `PTMR_OFF_CONTROL: rdata_reg <= control_reg;
                `PTMR_OFF_COUNT:   rdata_reg <= count_reg;
                `PTMR_OFF_PERIOD:  rdata_reg <= period_reg;
                `PTMR_OFF_FLAGS:   rdata_reg <= flags_reg;
                `PTMR_OFF_ENABLE:  rdata_reg <= enable_reg;
                default:           rdata_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq       = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_wrap_zero: assert property (@(posedge mclk) disable iff (srst)
        pre_tick && match && !wr_cnt |=> count_reg == 8'h00)
        else $error("count did not wrap on match");
    a_count_step: assert property (@(posedge mclk) disable iff (srst)
        pre_tick && !match && !wr_cnt |=> count_reg == $past(count_reg) + 8'h01)
        else $error("count did not step");
    a_halt_hold: assert property (@(posedge mclk) disable iff (srst)
        !run && !wr_cnt |=> $stable(count_reg))
        else $error("halted count moved");
    a_ctl_keeps: assert property (@(posedge mclk) disable iff (srst)
        wr_ctl && !pre_tick |=> $stable(count_reg) && pre_reg == 4'h0 && post_reg == 4'h0)
        else $error("control write disturbed count or scalers");
    a_cnt_clears: assert property (@(posedge mclk) disable iff (srst)
        wr_cnt |=> pre_reg == 4'h0 && post_reg == 4'h0 && count_reg == $past(reg_wdata))
        else $error("count write handling wrong");
    a_flag_set: assert property (@(posedge mclk) disable iff (srst)
        post_tick |=> flags_reg[`PTMR_MATCH_BIT])
        else $error("flag not set by postscaler");
    a_bit7_zero: assert property (@(posedge mclk) disable iff (srst)
        !control_reg[7])
        else $error("control bit 7 set");
    a_irq_gate: assert property (@(posedge mclk) disable iff (srst)
        ##1 irq == $past(flags_reg[`PTMR_MATCH_BIT] && enable_reg[`PTMR_MATCH_BIT]))
        else $error("interrupt not gated by enable");
    a_div1_rate: assert property (@(posedge mclk) disable iff (srst)
        pre_tick |=> !pre_tick [*3])
        else $error("ticks closer than instruction clock");
    a_post_flag_hold: assert property (@(posedge mclk) disable iff (srst)
        flags_reg[`PTMR_MATCH_BIT] && !wr_flg |=> flags_reg[`PTMR_MATCH_BIT])
        else $error("flag dropped without clear");

    ////////////////////////////////////////////////////////////////////////
    // Tick chain checks
    // These watch the scaler counters themselves, so a fault in the
    // tick chain shows up before it reaches the count or the flag

    // Instruction phase steps by one on every edge while on
    a_instr_step: assert property (@(posedge mclk) disable iff (srst)
        run
        |=> instr_reg == $past(instr_reg) + 2'h1)
        else $error("instruction phase did not step");

    // Divide by one passes every instruction tick straight through
    a_div1_every: assert property (@(posedge mclk) disable iff (srst)
        instr_tick && pre_sel == PTMR_PRE_DIV1
        |-> pre_tick)
        else $error("divide by one dropped a tick");

    // Prescaler never runs past its terminal count
    a_pre_bound: assert property (@(posedge mclk) disable iff (srst)
        pre_reg <= pre_tc)
        else $error("prescaler beyond terminal count");

    // A halted timer produces no ticks at all
    a_run_gate: assert property (@(posedge mclk) disable iff (srst)
        !run
        |-> !instr_tick && !pre_tick)
        else $error("tick while halted");

    // Halted scalers keep their place unless a write clears them
    a_halt_still: assert property (@(posedge mclk) disable iff (srst)
        !run && !wr_ctl && !wr_cnt
        |=> $stable(instr_reg) && $stable(pre_reg) && $stable(post_reg))
        else $error("halted scaler moved");

    ////////////////////////////////////////////////////////////////////////
    // Postscaler and flag checks
    // The postscaler must move only on a match, or a slow period
    // would raise the flag early

    // Each match steps the postscaler unless it wraps
    a_post_step: assert property (@(posedge mclk) disable iff (srst)
        pre_tick && match && !post_tick && !wr_ctl && !wr_cnt
        |=> post_reg == $past(post_reg) + 4'h1)
        else $error("postscaler did not step on match");

    // Without a match the postscaler holds
    a_post_only_match: assert property (@(posedge mclk) disable iff (srst)
        !(pre_tick && match) && !wr_ctl && !wr_cnt
        |=> $stable(post_reg))
        else $error("postscaler moved without match");

    // Postscaler never runs past the selected count
    a_post_bound: assert property (@(posedge mclk) disable iff (srst)
        post_reg <= post_sel)
        else $error("postscaler beyond select");

    // Flag rises only from a postscaler output
    a_flag_only_post: assert property (@(posedge mclk) disable iff (srst)
        !flags_reg[`PTMR_MATCH_BIT] && !post_tick
        |=> !flags_reg[`PTMR_MATCH_BIT])
        else $error("flag set without event");

    // Writing one clears the flag when no event competes
    a_flag_clear: assert property (@(posedge mclk) disable iff (srst)
        wr_flg && reg_wdata[`PTMR_MATCH_BIT] && !post_tick
        |=> !flags_reg[`PTMR_MATCH_BIT])
        else $error("flag not cleared by write");

    // Only the match bit exists in flags and enable
    a_irq_bits: assert property (@(posedge mclk) disable iff (srst)
        (flags_reg & ~`PTMR_IRQ_WMASK) == 8'h00
        && (enable_reg & ~`PTMR_IRQ_WMASK) == 8'h00)
        else $error("unimplemented interrupt bit set");

    // A masked flag never reaches the request line
    a_irq_masked: assert property (@(posedge mclk) disable iff (srst)
        !enable_reg[`PTMR_MATCH_BIT]
        |=> !irq)
        else $error("interrupt while masked");

    ////////////////////////////////////////////////////////////////////////
    // Register port checks
    // Read data is zero outside its one cycle, so software that
    // samples late sees zero rather than stale data

    // Read data stands only in the cycle after a strobe
    a_read_stand: assert property (@(posedge mclk) disable iff (srst)
        !reg_rd
        |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");

    // Count read returns the count as of the strobe edge
    a_read_count: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && reg_addr == `PTMR_OFF_COUNT
        |=> reg_rdata == $past(count_reg))
        else $error("count read wrong");

    // Period write lands in full
    a_period_write: assert property (@(posedge mclk) disable iff (srst)
        wr_per
        |=> period_reg == $past(reg_wdata))
        else $error("period write lost");

    // Control read never shows bit 7
    a_read_ctl: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && reg_addr == `PTMR_OFF_CONTROL
        |=> !reg_rdata[7])
        else $error("control bit 7 read as one");

    // Any control write clears both scalers, tick or not
    a_ctl_clears: assert property (@(posedge mclk) disable iff (srst)
        wr_ctl
        |=> pre_reg == 4'h0 && post_reg == 4'h0)
        else $error("control write left scalers");

    // Reset values; deliberately not disabled by reset
    a_reset_vals: assert property (@(posedge mclk)
        srst
        |=> count_reg == 8'h00 && period_reg == 8'hFF
        && pre_reg == 4'h0 && post_reg == 4'h0)
        else $error("reset values wrong");

    ////////////////////////////////////////////////////////////////////////
    // Scenario covers
    c_wrap: cover property (@(posedge mclk) pre_tick && match);
    c_post2: cover property (@(posedge mclk) post_tick && post_sel == 4'h1);
    c_flag: cover property (@(posedge mclk) post_tick && post_sel == 4'hF);
    c_irq:  cover property (@(posedge mclk) irq);
    c_div16: cover property (@(posedge mclk) pre_tick && pre_sel == PTMR_PRE_DIV16B);

endmodule

// *** test/test_period_timer_8bit_pre_post.sv ***
// Self-checking bench for the 8-bit period timer
// Assumes ptmr_timer and the map header compiled from core/
`include "ptmr_map.svh"

module test_period_timer_8bit_pre_post;
    timeunit 1ns;
    timeprecision 1ns;

    logic       mclk      = 1'b0;
    logic       srst      = 1'b1;
    logic [2:0] reg_addr  = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata;
    logic       irq;
    logic [7:0] rd_val;
    logic [7:0] first;
    int         miscompares = 0;
    int         tests_run   = 0;
    int         cycles      = 0;

    ////////////////////////////////////////////////////////////////
    // 20 MHz clock
    always #25 mclk = ~mclk;

    ptmr_timer uut (
        .mclk      (mclk),
        .srst      (srst),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .irq       (irq)
    );

    ////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic reset_values();
        logic [7:0] rv [6];
        rv = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(3'(i));
            check("reset value", rd_val, rv[i]);
        end
        wr(3'h5, 8'hFF);
        rd(3'h5);
        check("unmapped read", rd_val, 8'h00);
    endtask

    task automatic reg_access();
        wr(`PTMR_OFF_CONTROL, 8'hFB);
        rd(`PTMR_OFF_CONTROL);
        check("control bit7", rd_val, 8'h7B);
        wr(`PTMR_OFF_COUNT, 8'h5A);
        wr(`PTMR_OFF_PERIOD, 8'hA5);
        rd(`PTMR_OFF_COUNT);
        check("count rw", rd_val, 8'h5A);
        rd(`PTMR_OFF_PERIOD);
        check("period rw", rd_val, 8'hA5);
        wr(`PTMR_OFF_CONTROL, 8'h00);
        rd(`PTMR_OFF_COUNT);
        check("count after control", rd_val, 8'h5A);
    endtask

    // Any window of 4 pulse periods holds exactly 4 pulses, whatever the phase
    task automatic prescale_rates();
        int p;
        wr(`PTMR_OFF_PERIOD, 8'hFF);
        for (int c = 0; c < 4; c++) begin
            p = (c == 0) ? 4 : (c == 1) ? 16 : 64;
            wr(`PTMR_OFF_COUNT, 8'h00);
            wr(`PTMR_OFF_CONTROL, 8'h04 | 8'(c));
            idle(3);
            rd(`PTMR_OFF_COUNT);
            first = rd_val;
            idle(4 * p - 2);
            rd(`PTMR_OFF_COUNT);
            check("prescale steps", rd_val - first, 8'h04);
        end
        wr(`PTMR_OFF_CONTROL, 8'h00);
        rd(`PTMR_OFF_COUNT);
        first = rd_val;
        idle(100);
        rd(`PTMR_OFF_COUNT);
        check("halted count", rd_val, first);
    endtask

    // Period 2 gives a match every 3 pulses; flag after k+1 matches
    task automatic postscale_flag();
        int k [3] = '{0, 1, 15};
        int t;
        wr(`PTMR_OFF_PERIOD, 8'h02);
        foreach (k[i]) begin
            wr(`PTMR_OFF_FLAGS, 8'h02);
            wr(`PTMR_OFF_COUNT, 8'h00);
            wr(`PTMR_OFF_CONTROL, 8'(k[i] << 3) | 8'h04);
            t = 12 * (k[i] + 1);
            idle(t - 8);
            rd(`PTMR_OFF_FLAGS);
            check("flag early", rd_val, 8'h00);
            idle(8);
            rd(`PTMR_OFF_FLAGS);
            check("flag on time", rd_val, 8'h02);
            wr(`PTMR_OFF_CONTROL, 8'h00);
        end
    endtask

    task automatic irq_path();
        check("irq masked", 8'(irq), 8'h00);
        wr(`PTMR_OFF_ENABLE, 8'hFF);
        idle(2);
        check("irq enabled", 8'(irq), 8'h01);
        rd(`PTMR_OFF_ENABLE);
        check("enable bits", rd_val, 8'h02);
        rd(`PTMR_OFF_FLAGS);
        check("flag sticky", rd_val, 8'h02);
        wr(`PTMR_OFF_FLAGS, 8'h02);
        idle(2);
        check("irq cleared", 8'(irq), 8'h00);
    endtask

    // Writes every 40 cycles keep a 64-cycle prescaler from ever firing
    task automatic scaler_clear();
        wr(`PTMR_OFF_COUNT, 8'h10);
        wr(`PTMR_OFF_CONTROL, 8'h06);
        repeat (4) begin
            idle(38);
            wr(`PTMR_OFF_COUNT, 8'h10);
        end
        rd(`PTMR_OFF_COUNT);
        check("count write clear", rd_val, 8'h10);
        repeat (4) begin
            idle(38);
            wr(`PTMR_OFF_CONTROL, 8'h06);
        end
        rd(`PTMR_OFF_COUNT);
        check("control write clear", rd_val, 8'h10);
        wr(`PTMR_OFF_CONTROL, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////
    // Hang guard, well above the roughly 1400 cycles needed
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        idle(5);
        srst <= 1'b0;
        reset_values();
        reg_access();
        prescale_rates();
        postscale_flag();
        irq_path();
        scaler_clear();
        finish_test();
    end
endmodule
